// [pdm_pkg.sv]
// Constants shared by the program/data space mapper.
package pdm_pkg;
  localparam int PA_W = 24;
  localparam int DA_W = 16;
  localparam int DW = 16;
  localparam int PAGE_W = 8;
  localparam int WB_AW = 8;
  // Core request operations.
  localparam logic [2:0] OP_DATA_RD = 3'h0;
  localparam logic [2:0] OP_DATA_WR = 3'h1;
  localparam logic [2:0] OP_TBL_RD_LOW = 3'h2;
  localparam logic [2:0] OP_TBL_RD_HIGH = 3'h3;
  localparam logic [2:0] OP_TBL_WR_LOW = 3'h4;
  localparam logic [2:0] OP_TBL_WR_HIGH = 3'h5;
  localparam logic [2:0] OP_MAC_RD = 3'h6;
  // Instruction classes for the extra-cycle count.
  localparam logic [1:0] CLS_MAC_PREFETCH = 2'h0;
  localparam logic [1:0] CLS_MOVE_WORD = 2'h1;
  localparam logic [1:0] CLS_MOVE_DOUBLE = 2'h2;
  localparam logic [1:0] CLS_OTHER = 2'h3;
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_SHORT = 2'h1;
  localparam logic [1:0] EXTRA_LONG = 2'h2;
  // Working register numbers used as multiply-accumulate pointers.
  localparam logic [3:0] PTR_X_A = 4'h8;
  localparam logic [3:0] PTR_X_B = 4'h9;
  localparam logic [3:0] PTR_Y_A = 4'hA;
  localparam logic [3:0] PTR_Y_B = 4'hB;
  // Fixed data space layout.
  localparam logic [15:0] Y_FIRST = 16'h1800;
  localparam logic [15:0] Y_LAST = 16'h1FFF;
  localparam logic [15:0] DM_LAST = 16'h27FF;
  localparam int EA_MSB = 15;
  localparam int CFG_SPACE_BIT = 7;
  // Register byte offsets.
  localparam logic [7:0] REG_CORE_CONTROL = 8'h00;
  localparam logic [7:0] REG_PROGRAM_VIEW_PAGE = 8'h04;
  localparam logic [7:0] REG_TABLE_PAGE = 8'h08;
  localparam logic [7:0] REG_X_MOD_START = 8'h0C;
  localparam logic [7:0] REG_X_MOD_END = 8'h10;
  localparam logic [7:0] REG_Y_MOD_START = 8'h14;
  localparam logic [7:0] REG_Y_MOD_END = 8'h18;
  localparam logic [7:0] REG_BITREV_WIDTH = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  // Core control fields.
  localparam int CC_PROGRAM_VIEW_ENABLE = 0;
  localparam int CC_X_MOD_EN = 1;
  localparam int CC_Y_MOD_EN = 2;
  localparam int CC_BITREV_EN = 3;
  localparam int CC_W = 4;
  // Status fields.
  localparam int ST_BUSY = 0;
  localparam int ST_REDIRECTED = 1;
  localparam int ST_INVALID = 2;
  localparam int ST_TABLE_CFG = 3;
  // Reset values.
  localparam logic [CC_W-1:0] CORE_CONTROL_RST = 4'h0;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] MOD_START_RST = 16'h0000;
  localparam logic [15:0] MOD_END_RST = 16'hFFFE;
  localparam logic [3:0] BITREV_WIDTH_RST = 4'h0;
endpackage : pdm_pkg

// [pdm_read_format.sv]
// Read-data formatter: places program or data words on the 16-bit X read path.
`timescale 1ns/1ps
module pdm_read_format
(
  input wire logic [2:0] op_i,
  input wire logic byte_i,
  input wire logic byte_sel_i,
  input wire logic from_pm_i,
  input wire logic zero_i,
  input wire logic [pdm_pkg::PA_W-1:0] pm_word_i,
  input wire logic [pdm_pkg::DW-1:0] dm_word_i,
  output logic [pdm_pkg::DW-1:0] data_o
);
  import pdm_pkg::*;

  logic [DW-1:0] low_word;

  always_comb
  begin
    low_word = from_pm_i ? pm_word_i[15:0] : dm_word_i;
    if (zero_i)
    begin
      data_o = 16'h0000;
    end
    else if (op_i == OP_TBL_RD_HIGH)
    begin
      data_o = (byte_i && byte_sel_i) ? 16'h0000 : {8'h00, pm_word_i[23:16]};
    end
    else if (byte_i)
    begin
      data_o = {8'h00, byte_sel_i ? low_word[15:8] : low_word[7:0]};
    end
    else
    begin
      data_o = low_word;
    end
  end
endmodule : pdm_read_format

// [pdm_mapper.sv]
// Program/data space mapper: table access, program view window and X/Y data paths.
// Behaviour
// - Program words are 24 bits; program addresses step by two per word.
// - Only high table operations reach the upper program byte as data.
// - Low table ops use the low word space, high ops the upper byte space.
// - Word low table read returns program bits 15..0 unchanged.
// - Byte low table read returns bits 7..0 or 15..8 by byte select.
// - Word high table read returns bits 23..16 low, upper byte zero.
// - Byte high table read returns bits 23..16 on select zero, else zero.
// - Upper 32 Kbytes of data space map onto any 16K-word program page.
// - Redirect only when address bit 15 and program view enable are set.
// - Redirected address: low 15 EA bits, page register gives bits 22..15.
// - A redirected read returns only the low 16 bits of the program word.
// - Program view redirection is suspended during table reads and writes.
// - Outside repeat: one extra cycle for prefetch/move classes, else two.
// - In repeat: two extra on first, last, interrupt exit, re-entry; else none.
// - Data addresses are 16-bit byte addresses spanning 64 Kbytes.
// - Non multiply-accumulate accesses see all data space linearly over X.
// - MAC reads use W10/W11 for Y, W8/W9 for X, both concurrently.
// - All data writes use the X write bus; the Y bus never writes.
// - Bit-reversed addressing only for X writes; modulo on X and Y.
// - Y serves only MAC prefetch; X/Y boundary is fixed.
// - Unimplemented addresses and wrong-space MAC pointers read as zero.
// - Table address is table page plus EA; page bit 7 selects config space.
`timescale 1ns/1ps
module pdm_mapper
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pdm_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [2:0] req_op_i,
  input wire logic req_byte_i,
  input wire logic [pdm_pkg::DA_W-1:0] req_ea_i,
  input wire logic [pdm_pkg::DW-1:0] req_wdata_i,
  input wire logic [1:0] req_class_i,
  input wire logic rep_active_i,
  input wire logic rep_first_i,
  input wire logic rep_last_i,
  input wire logic rep_int_exit_i,
  input wire logic rep_reenter_i,
  input wire logic [pdm_pkg::DA_W-1:0] mac_y_ea_i,
  input wire logic [3:0] mac_x_ptr_i,
  input wire logic [3:0] mac_y_ptr_i,
  output logic done_o,
  output logic [pdm_pkg::DW-1:0] x_rdata_o,
  output logic [pdm_pkg::DW-1:0] y_rdata_o,
  output logic redirected_o,
  output logic [pdm_pkg::PA_W-1:0] pm_addr_o,
  output logic pm_rd_o,
  output logic pm_wr_o,
  output logic [2:0] pm_lane_o,
  output logic [pdm_pkg::PA_W-1:0] pm_wdata_o,
  input wire logic [pdm_pkg::PA_W-1:0] pm_rdata_i,
  output logic [pdm_pkg::DA_W-1:0] dm_addr_o,
  output logic dm_rd_o,
  output logic dm_wr_o,
  output logic [1:0] dm_be_o,
  output logic [pdm_pkg::DW-1:0] dm_wdata_o,
  input wire logic [pdm_pkg::DW-1:0] dm_rdata_i,
  output logic [pdm_pkg::DA_W-1:0] ym_addr_o,
  output logic ym_rd_o,
  input wire logic [pdm_pkg::DW-1:0] ym_rdata_i
);
  import pdm_pkg::*;

  typedef enum logic [3:0]
  {
    S_IDLE = 4'h1,
    S_ACCESS = 4'h2,
    S_STALL = 4'h4,
    S_DONE = 4'h8
  } pdm_state_t;

  function automatic logic in_y(input logic [15:0] ea);
    in_y = (ea >= Y_FIRST) && (ea <= Y_LAST);
  endfunction : in_y

  // Modulo wrap for a pointer that has stepped one word past either end.
  function automatic logic [15:0] wrap(input logic [15:0] ea, input logic [15:0] s,
                                       input logic [15:0] e);
    wrap = (ea > e) ? s : ((ea < s) ? (e & 16'hFFFE) : ea);
  endfunction : wrap

  function automatic logic [15:0] bit_rev(input logic [15:0] ea, input logic [3:0] n);
    bit_rev = ea;
    for (int i = 0; i < 16; i++)
    begin
      if (i < int'(n))
      begin
        bit_rev[i] = ea[int'(n) - 1 - i];
      end
    end
  endfunction : bit_rev

  function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] sel);
    lane_write = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : lane_write

  pdm_state_t state_reg;
  logic [CC_W-1:0] core_control_reg;
  logic [PAGE_W-1:0] program_view_page_reg;
  logic [PAGE_W-1:0] table_page_reg;
  logic [15:0] x_mod_start_reg;
  logic [15:0] x_mod_end_reg;
  logic [15:0] y_mod_start_reg;
  logic [15:0] y_mod_end_reg;
  logic [3:0] bitrev_width_reg;
  logic [2:0] op_reg;
  logic byte_reg;
  logic byte_sel_reg;
  logic from_pm_reg;
  logic x_zero_reg;
  logic y_zero_reg;
  logic invalid_reg;
  logic table_cfg_reg;
  logic [1:0] extra_reg;
  logic [1:0] stall_cnt_reg;
  logic ack_reg;
  logic [31:0] wb_dat_reg;

  logic accept;
  logic is_table;
  logic is_write;
  logic is_mac;
  logic redirect;
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic x_bad;
  logic y_bad;
  logic [1:0] extra_next;
  logic [DW-1:0] x_fmt;
  logic wb_req;

  assign accept = req_valid_i && (state_reg == S_IDLE);
  assign req_ready_o = (state_reg == S_IDLE);
  assign done_o = (state_reg == S_DONE);
  assign is_table = (req_op_i >= OP_TBL_RD_LOW) && (req_op_i <= OP_TBL_WR_HIGH);
  assign is_write = (req_op_i == OP_DATA_WR);
  assign is_mac = (req_op_i == OP_MAC_RD);
  // Table operations see program space directly, so the window must not steer them.
  assign redirect = !is_table && req_ea_i[EA_MSB]
                    && core_control_reg[CC_PROGRAM_VIEW_ENABLE];

  // X address: modulo for all, bit reversal only when writing.
  always_comb
  begin
    x_ea = core_control_reg[CC_X_MOD_EN] ?
           wrap(req_ea_i, x_mod_start_reg, x_mod_end_reg) : req_ea_i;
    if (is_write && core_control_reg[CC_BITREV_EN])
    begin
      x_ea = bit_rev(x_ea, bitrev_width_reg);
    end
    y_ea = core_control_reg[CC_Y_MOD_EN] ?
           wrap(mac_y_ea_i, y_mod_start_reg, y_mod_end_reg) : mac_y_ea_i;
  end

  // Invalid reads: outside physical memory, or the wrong pointer/space pairing.
  always_comb
  begin
    x_bad = !redirect && !is_table && (x_ea > DM_LAST);
    y_bad = 1'b0;
    if (is_mac)
    begin
      x_bad = x_bad || (!redirect && in_y(x_ea))
              || !((mac_x_ptr_i == PTR_X_A) || (mac_x_ptr_i == PTR_X_B));
      y_bad = !in_y(y_ea)
              || !((mac_y_ptr_i == PTR_Y_A) || (mac_y_ptr_i == PTR_Y_B));
    end
  end

  always_comb
  begin
    extra_next = EXTRA_NONE;
    if (redirect)
    begin
      if (rep_active_i)
      begin
        if (rep_first_i || rep_last_i || rep_int_exit_i || rep_reenter_i)
        begin
          extra_next = EXTRA_LONG;
        end
      end
      else if (req_class_i != CLS_OTHER)
      begin
        extra_next = EXTRA_SHORT;
      end
      else
      begin
        extra_next = EXTRA_LONG;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_IDLE;
      stall_cnt_reg <= EXTRA_NONE;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (accept)
          begin
            state_reg <= S_ACCESS;
          end
        end
        S_ACCESS:
        begin
          stall_cnt_reg <= extra_reg;
          state_reg <= (extra_reg == EXTRA_NONE) ? S_DONE : S_STALL;
        end
        S_STALL:
        begin
          stall_cnt_reg <= stall_cnt_reg - 2'h1;
          if (stall_cnt_reg == EXTRA_SHORT)
          begin
            state_reg <= S_DONE;
          end
        end
        S_DONE:
        begin
          state_reg <= S_IDLE;
        end
        default:
        begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Request context, kept for the formatter and status.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_reg <= OP_DATA_RD;
      byte_reg <= 1'b0;
      byte_sel_reg <= 1'b0;
      from_pm_reg <= 1'b0;
      x_zero_reg <= 1'b0;
      y_zero_reg <= 1'b0;
      invalid_reg <= 1'b0;
      table_cfg_reg <= 1'b0;
      extra_reg <= EXTRA_NONE;
      redirected_o <= 1'b0;
    end
    else if (accept)
    begin
      op_reg <= req_op_i;
      byte_reg <= req_byte_i;
      byte_sel_reg <= req_ea_i[0];
      from_pm_reg <= is_table || redirect;
      x_zero_reg <= x_bad;
      y_zero_reg <= y_bad;
      invalid_reg <= x_bad || y_bad;
      table_cfg_reg <= is_table && table_page_reg[CFG_SPACE_BIT];
      extra_reg <= extra_next;
      redirected_o <= redirect;
    end
  end

  // Memory strobes: one cycle long, in the cycle after the request is taken.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pm_addr_o <= 24'h000000;
      pm_rd_o <= 1'b0;
      pm_wr_o <= 1'b0;
      pm_lane_o <= 3'h0;
      pm_wdata_o <= 24'h000000;
      dm_addr_o <= 16'h0000;
      dm_rd_o <= 1'b0;
      dm_wr_o <= 1'b0;
      dm_be_o <= 2'h0;
      dm_wdata_o <= 16'h0000;
      ym_addr_o <= 16'h0000;
      ym_rd_o <= 1'b0;
    end
    else
    begin
      pm_rd_o <= 1'b0;
      pm_wr_o <= 1'b0;
      dm_rd_o <= 1'b0;
      dm_wr_o <= 1'b0;
      ym_rd_o <= 1'b0;
      if (accept)
      begin
        if (is_table)
        begin
          // Word address: bit 0 is only the byte select, so words step by two.
          pm_addr_o <= {table_page_reg, req_ea_i[15:1], 1'b0};
          pm_rd_o <= (req_op_i == OP_TBL_RD_LOW) || (req_op_i == OP_TBL_RD_HIGH);
          pm_wr_o <= (req_op_i == OP_TBL_WR_LOW) || (req_op_i == OP_TBL_WR_HIGH);
          if (req_op_i == OP_TBL_WR_HIGH)
          begin
            pm_wdata_o <= {req_wdata_i[7:0], 16'h0000};
            pm_lane_o <= (req_byte_i && req_ea_i[0]) ? 3'h0 : 3'h4;
          end
          else
          begin
            pm_wdata_o <= {8'h00, req_byte_i ? {2{req_wdata_i[7:0]}} : req_wdata_i};
            pm_lane_o <= !req_byte_i ? 3'h3 : (req_ea_i[0] ? 3'h2 : 3'h1);
          end
        end
        else if (redirect)
        begin
          pm_addr_o <= {1'b0, program_view_page_reg, req_ea_i[14:1], 1'b0};
          pm_rd_o <= !is_write;
          pm_lane_o <= 3'h0;
        end
        else
        begin
          dm_addr_o <= x_ea;
          dm_rd_o <= !is_write && !x_bad;
          dm_wr_o <= is_write && (x_ea <= DM_LAST);
          dm_be_o <= !req_byte_i ? 2'h3 : (x_ea[0] ? 2'h2 : 2'h1);
          dm_wdata_o <= req_byte_i ? {2{req_wdata_i[7:0]}} : req_wdata_i;
        end
        if (is_mac)
        begin
          ym_addr_o <= y_ea;
          ym_rd_o <= !y_bad;
        end
      end
    end
  end

  pdm_read_format u_read_format
  (
    .op_i(op_reg),
    .byte_i(byte_reg),
    .byte_sel_i(byte_sel_reg),
    .from_pm_i(from_pm_reg),
    .zero_i(x_zero_reg),
    .pm_word_i(pm_rdata_i),
    .dm_word_i(dm_rdata_i),
    .data_o(x_fmt)
  );

  // Results are captured once and then held through the stall cycles.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      x_rdata_o <= 16'h0000;
      y_rdata_o <= 16'h0000;
    end
    else if ((state_reg == S_ACCESS) && (op_reg != OP_DATA_WR)
             && (op_reg != OP_TBL_WR_LOW) && (op_reg != OP_TBL_WR_HIGH))
    begin
      x_rdata_o <= x_fmt;
      y_rdata_o <= y_zero_reg ? 16'h0000 : ym_rdata_i;
    end
  end

  // Wishbone classic slave: ack one cycle after the strobe, dropped the next.
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = wb_dat_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      wb_dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          REG_CORE_CONTROL: wb_dat_reg <= {28'h0000000, core_control_reg};
          REG_PROGRAM_VIEW_PAGE: wb_dat_reg <= {24'h000000, program_view_page_reg};
          REG_TABLE_PAGE: wb_dat_reg <= {24'h000000, table_page_reg};
          REG_X_MOD_START: wb_dat_reg <= {16'h0000, x_mod_start_reg};
          REG_X_MOD_END: wb_dat_reg <= {16'h0000, x_mod_end_reg};
          REG_Y_MOD_START: wb_dat_reg <= {16'h0000, y_mod_start_reg};
          REG_Y_MOD_END: wb_dat_reg <= {16'h0000, y_mod_end_reg};
          REG_BITREV_WIDTH: wb_dat_reg <= {28'h0000000, bitrev_width_reg};
          REG_STATUS: wb_dat_reg <= {28'h0000000, table_cfg_reg, invalid_reg,
                                     redirected_o, (state_reg != S_IDLE)};
          default: wb_dat_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // Register writes; the X/Y boundary has no register and cannot be moved.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_control_reg <= CORE_CONTROL_RST;
      program_view_page_reg <= PAGE_RST;
      table_page_reg <= PAGE_RST;
      x_mod_start_reg <= MOD_START_RST;
      x_mod_end_reg <= MOD_END_RST;
      y_mod_start_reg <= MOD_START_RST;
      y_mod_end_reg <= MOD_END_RST;
      bitrev_width_reg <= BITREV_WIDTH_RST;
    end
    else if (wb_req && wb_we_i && (wb_sel_i[1:0] != 2'h0))
    begin
      case (wb_adr_i)
        REG_CORE_CONTROL: if (wb_sel_i[0]) core_control_reg <= wb_dat_i[CC_W-1:0];
        REG_PROGRAM_VIEW_PAGE: if (wb_sel_i[0]) program_view_page_reg <= wb_dat_i[7:0];
        REG_TABLE_PAGE: if (wb_sel_i[0]) table_page_reg <= wb_dat_i[7:0];
        REG_X_MOD_START: x_mod_start_reg <= lane_write(x_mod_start_reg, wb_dat_i, wb_sel_i);
        REG_X_MOD_END: x_mod_end_reg <= lane_write(x_mod_end_reg, wb_dat_i, wb_sel_i);
        REG_Y_MOD_START: y_mod_start_reg <= lane_write(y_mod_start_reg, wb_dat_i, wb_sel_i);
        REG_Y_MOD_END: y_mod_end_reg <= lane_write(y_mod_end_reg, wb_dat_i, wb_sel_i);
        REG_BITREV_WIDTH: if (wb_sel_i[0]) bitrev_width_reg <= wb_dat_i[3:0];
        default:
        begin
        end
      endcase
    end
  end
endmodule : pdm_mapper

// [pdm_checker.sv]
// Port-level assertions for the program/data space mapper.
`timescale 1ns/1ps
module pdm_checker
  import pdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic [2:0] req_op_i,
  input wire logic [pdm_pkg::DA_W-1:0] req_ea_i,
  input wire logic [pdm_pkg::DA_W-1:0] mac_y_ea_i,
  input wire logic done_o,
  input wire logic [pdm_pkg::DW-1:0] x_rdata_o,
  input wire logic [pdm_pkg::PA_W-1:0] pm_addr_o,
  input wire logic pm_rd_o,
  input wire logic dm_wr_o,
  input wire logic [pdm_pkg::DA_W-1:0] ym_addr_o,
  input wire logic ym_rd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  logic [2:0] op_q;
  logic [15:0] ea_q;
  logic [15:0] yea_q;
  assign acc = req_valid_i && req_ready_o;
  // Copies of the request let consequents slice what was taken one edge before.
  always_ff @(posedge clk_i)
  begin
    op_q <= req_op_i;
    ea_q <= req_ea_i;
    yea_q <= mac_y_ea_i;
  end
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing");
  property p_redir;
    acc && req_op_i == OP_DATA_RD && req_ea_i[EA_MSB] |=>
      !pm_rd_o || (pm_addr_o[14:0] == {ea_q[14:1], 1'b0} && !pm_addr_o[23]);
  endproperty
  a_redir: assert property (p_redir) else $error("window address");
  property p_tbl_addr;
    acc && (req_op_i == OP_TBL_RD_LOW || req_op_i == OP_TBL_RD_HIGH) |=>
      pm_rd_o && pm_addr_o[15:0] == {ea_q[15:1], 1'b0};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address");
  property p_tbl_time;
    acc && req_op_i >= OP_TBL_RD_LOW && req_op_i <= OP_TBL_WR_HIGH |-> ##2 done_o;
  endproperty
  a_tbl_time: assert property (p_tbl_time) else $error("table op slowed");
  property p_busy;
    acc |=> !req_ready_o throughout (##[1:3] done_o);
  endproperty
  a_busy: assert property (p_busy) else $error("request length");
  property p_ready_back;
    done_o |=> req_ready_o && !done_o;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("not ready after done");
  property p_ym;
    ym_rd_o |-> op_q == OP_MAC_RD && ym_addr_o == yea_q;
  endproperty
  a_ym: assert property (p_ym) else $error("Y read outside dual read");
  property p_dm_wr;
    dm_wr_o |-> op_q == OP_DATA_WR;
  endproperty
  a_dm_wr: assert property (p_dm_wr) else $error("stray data write");
  property p_x_hold;
    !req_ready_o && !$past(req_ready_o) |=> $stable(x_rdata_o);
  endproperty
  a_x_hold: assert property (p_x_hold) else $error("X result moved");
endmodule : pdm_checker
bind pdm_mapper pdm_checker i_pdm_checker (.*);

// [pdm_mem_model.sv]
// Behavioural program, X and Y memories facing the mapper.
`timescale 1ns/1ps
module pdm_mem_model
  import pdm_pkg::*;
(
  input wire logic [pdm_pkg::PA_W-1:0] pm_addr_i,
  input wire logic pm_rd_i,
  output logic [pdm_pkg::PA_W-1:0] pm_rdata_o,
  input wire logic [pdm_pkg::DA_W-1:0] dm_addr_i,
  input wire logic dm_rd_i,
  output logic [pdm_pkg::DW-1:0] dm_rdata_o,
  input wire logic [pdm_pkg::DA_W-1:0] ym_addr_i,
  input wire logic ym_rd_i,
  output logic [pdm_pkg::DW-1:0] ym_rdata_o
);
  // Contents are a fixed function of the address so any word can be predicted.
  function automatic logic [23:0] pmv(input logic [23:0] a);
    return {a[22:15] ^ a[8:1], a[16:1] ^ {a[22:15], 8'h5A}};
  endfunction : pmv
  function automatic logic [15:0] dmv(input logic [15:0] a);
    return {a[15:1], 1'b1} ^ 16'h3C96;
  endfunction : dmv
  // Without a strobe the buses carry the inverse, so a mistimed capture is seen.
  assign pm_rdata_o = pm_rd_i ? pmv(pm_addr_i) : ~pmv(pm_addr_i);
  assign dm_rdata_o = dm_rd_i ? dmv(dm_addr_i) : ~dmv(dm_addr_i);
  assign ym_rdata_o = ym_rd_i ? dmv(ym_addr_i) : ~dmv(ym_addr_i);
endmodule : pdm_mem_model

// [tb.sv]
// Self-checking testbench for the program/data space mapper.
`timescale 1ns/1ps
module tb;
  import pdm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, seed = 32'had91;
  logic req_valid_i = 1'b0, req_byte_i = 1'b0, req_ready_o, done_o, redirected_o;
  logic [2:0] req_op_i = 3'h0, pm_lane_o, lane;
  logic [15:0] req_ea_i = 16'h0, req_wdata_i = 16'h0, mac_y_ea_i = 16'h0;
  logic [1:0] req_class_i = 2'h0, dm_be_o;
  logic rep_active_i = 1'b0, rep_first_i = 1'b0, rep_last_i = 1'b0;
  logic rep_int_exit_i = 1'b0, rep_reenter_i = 1'b0;
  logic [3:0] mac_x_ptr_i = 4'h8, mac_y_ptr_i = 4'hA;
  logic [15:0] x_rdata_o, y_rdata_o, dm_addr_o, dm_wdata_o, dm_rdata_i, ym_addr_o, ym_rdata_i;
  logic pm_rd_o, pm_wr_o, dm_rd_o, dm_wr_o, ym_rd_o;
  logic [23:0] pm_addr_o, pm_wdata_o, pm_rdata_i, p;
  logic [15:0] ea, m, wr_a, wr_d;
  logic [7:0] pg, tp;
  int errors = 0, cmp_count = 0, lat, n, wr_cnt = 0;
  pdm_mapper i_pdm_mapper (.*);
  pdm_mem_model i_pdm_mem_model (.pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o),
    .pm_rdata_o(pm_rdata_i), .dm_addr_i(dm_addr_o), .dm_rd_i(dm_rd_o), .dm_rdata_o(dm_rdata_i),
    .ym_addr_i(ym_addr_o), .ym_rd_i(ym_rd_o), .ym_rdata_o(ym_rdata_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [23:0] pmv(input logic [23:0] a);
    return {a[22:15] ^ a[8:1], a[16:1] ^ {a[22:15], 8'h5A}};
  endfunction : pmv
  function automatic logic [15:0] dmv(input logic [15:0] a);
    return {a[15:1], 1'b1} ^ 16'h3C96;
  endfunction : dmv
  function automatic int extra(input logic [1:0] c);
    if (rep_active_i)
      return (rep_first_i | rep_last_i | rep_int_exit_i | rep_reenter_i) ? 2 : 0;
    return (c == CLS_OTHER) ? 2 : 1;
  endfunction : extra
  function automatic logic [15:0] tbl_exp(input logic hi, by, sel, input logic [23:0] w);
    if (!hi)
      return by ? {8'h00, sel ? w[15:8] : w[7:0]} : w[15:0];
    return (by && sel) ? 16'h0000 : {8'h00, w[23:16]};
  endfunction : tbl_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic core(input logic [2:0] op, input logic [15:0] a);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_op_i <= op;
    req_ea_i <= a;
    do @(posedge clk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    lat = 0;
    while (done_o !== 1'b1)
    begin
      @(posedge clk_i);
      lat++;
    end
  endtask : core
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial forever #12.5 clk_i = ~clk_i;
  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
  // Write strobes are single-cycle, so each is caught once, on the edge after the one it appears on.
  always @(posedge clk_i)
  begin
    if (dm_wr_o === 1'b1 || pm_wr_o === 1'b1)
      wr_cnt++;
    if (dm_wr_o === 1'b1)
    begin
      wr_a = dm_addr_o;
      wr_d = dm_wdata_o;
    end
    if (pm_wr_o === 1'b1)
    begin
      wr_a = pm_addr_o[15:0];
      lane = pm_lane_o;
    end
  end
  initial
  begin
    logic [7:0] zr [4];
    logic [15:0] da [4];
    logic [15:0] wa [4];
    zr = '{REG_CORE_CONTROL, REG_PROGRAM_VIEW_PAGE, REG_TABLE_PAGE, 8'h24};
    da = '{16'h1800, 16'h27FE, 16'h2800, 16'hC000};
    wa = '{16'h0100, 16'h1802, 16'h2800, 16'h9000};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (zr[i])
    begin
      wb(1'b0, zr[i], 32'h0, q);
      chk(q, 32'h0);
    end
    wb(1'b0, REG_X_MOD_END, 32'h0, q);
    chk(q, 32'h0000FFFE);
    wb(1'b1, 8'h24, rnd(), q);
    wb(1'b0, 8'h24, 32'h0, q);
    chk(q, 32'h0);
    pg = 8'(rnd());
    wb(1'b1, REG_PROGRAM_VIEW_PAGE, {24'h0, pg}, q);
    wb(1'b0, REG_PROGRAM_VIEW_PAGE, 32'h0, q);
    chk(q, {24'h0, pg});
    $display("test registers done");
    wb(1'b1, REG_CORE_CONTROL, 32'h1, q);
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 6; r++)
      begin
        req_class_i <= c[1:0];
        rep_active_i <= (r != 0);
        {rep_reenter_i, rep_int_exit_i, rep_last_i, rep_first_i} <=
          (r > 0 && r < 5) ? 4'(1 << (r - 1)) : 4'h0;
        ea = 16'(rnd()) | 16'h8000;
        ea[0] = 1'b0;
        core(OP_DATA_RD, ea);
        p = pmv({1'b0, pg, ea[14:1], 1'b0});
        chk(x_rdata_o, p[15:0]);
        chk(lat, 2 + extra(c[1:0]));
        chk(redirected_o, 1'b1);
      end
    $display("test program window done");
    rep_active_i <= 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      tp = 8'(rnd());
      wb(1'b1, REG_TABLE_PAGE, {24'h0, tp}, q);
      req_byte_i <= k[1];
      ea = 16'(rnd()) | 16'h8000;
      ea[0] = k[2];
      core(k[0] ? OP_TBL_RD_HIGH : OP_TBL_RD_LOW, ea);
      p = pmv({tp, ea[15:1], 1'b0});
      m = k[1] ? 16'h00FF : 16'hFFFF;
      chk(x_rdata_o & m, tbl_exp(k[0], k[1], ea[0], p) & m);
      chk(lat, 2);
      wb(1'b0, REG_STATUS, 32'h0, q);
      chk(q[ST_TABLE_CFG], tp[7]);
    end
    $display("test table reads done");
    wb(1'b1, REG_CORE_CONTROL, 32'h0, q);
    req_byte_i <= 1'b0;
    foreach (da[i])
    begin
      core(OP_DATA_RD, da[i]);
      chk(x_rdata_o, da[i] <= DM_LAST ? dmv(da[i]) : 16'h0000);
    end
    for (int k = 0; k < 12; k++)
    begin
      q = rnd();
      ea = {3'b000, q[12:1], 1'b0};
      mac_y_ea_i <= 16'h1000 + {4'h0, q[27:17], 1'b0};
      mac_x_ptr_i <= 4'h8 + {2'b00, q[30:29]};
      mac_y_ptr_i <= 4'h8 + {2'b00, q[29:28]};
      core(OP_MAC_RD, ea);
      chk(x_rdata_o, (mac_x_ptr_i < 4'hA && ea < Y_FIRST) ? dmv(ea) : 16'h0);
      chk(y_rdata_o, (mac_y_ptr_i > 4'h9 && mac_y_ea_i >= Y_FIRST) ?
          dmv(mac_y_ea_i) : 16'h0);
    end
    $display("test data reads done");
    wb(1'b1, REG_CORE_CONTROL, 32'h1, q);
    foreach (wa[i])
    begin
      n = wr_cnt;
      req_wdata_i <= 16'(rnd());
      core(OP_DATA_WR, wa[i]);
      chk(wr_cnt - n, wa[i] <= DM_LAST);
      if (wa[i] <= DM_LAST)
      begin
        chk(wr_a, wa[i]);
        chk(dm_be_o, 2'h3);
        chk(wr_d, req_wdata_i);
      end
    end
    n = wr_cnt;
    core(OP_TBL_WR_LOW, 16'h0040);
    chk(lane, 3'b011);
    core(OP_TBL_WR_HIGH, 16'h0042);
    chk(lane, 3'b100);
    chk(pm_wdata_o, {req_wdata_i[7:0], 16'h0000});
    chk(wr_a, 16'h0042);
    chk(wr_cnt - n, 2);
    $display("test writes done");
    tally_and_finish();
  end
endmodule : tb
